// >>> rtl/mob_memory_order_barrier_unit.sv
// Memory ordering and barrier control between issue stage and data bus
// Contract
// - No atomic or exclusive access support provided.
// - Global observation only for shareable types.
// - Read observed once later write cannot change.
// - Access complete only when globally observed.
// - Strong side-effect access observed at bus acknowledge.
// - Listed device/strong pairs issue strictly in order.
// - Other pairs may overlap freely.
// - Instruction fetches never held by ordering.
// - Each multi-word transfer ordered separately.
// - Different instructions ordered by issue order.
// - Multi-word low address word goes first; not enforced, words issue in the order presented.
// - Multi-word loads with PC have no order.
// - Order barrier holds later accesses until observed.
// - Order barrier leaves non-memory instructions running.
// - Completion barrier ends after all accesses complete.
// - Nothing executes until completion barrier ends.
// - Flush barrier discards and refetches later instructions.
// - Later instructions see earlier context changes.
// - Branch prediction after flush uses new context.
// - Later context changes wait for flush barrier.
// - Barriers ignore fetch and DMA traffic.
`timescale 1ns/1ps
module mob_memory_order_barrier_unit
	import mob_pkg::*;
#(
	parameter int OUTS_W   = MOB_OUTS_W,
	parameter int OUTS_MAX = MOB_OUTS_MAX
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  accValid,
	input  wire logic                  accWrite,
	input  wire logic      [1:0]       accType,
	input  wire logic [MOB_ADDR_W-1:0] accAddr,
	input  wire logic                  accMulti,
	input  wire logic                  accMultiPc,
	output logic                       accReady,
	output logic                       busReqValid,
	output logic                       busReqWrite,
	output logic [MOB_ADDR_W-1:0]      busReqAddr,
	input  wire logic                  busReqReady,
	input  wire logic                  busObserved,
	input  wire logic      [1:0]       barOp,
	input  wire logic                  barValid,
	output logic                       barDone,
	output logic                       issueStall,
	output logic                       flushPipe,
	output logic                       ctxCommit,
	output logic                       outstandingEmpty
);
	// ==========================================================
	// Types and state
	typedef enum logic [2:0] {
		MOB_IDLE,
		MOB_ORDER_WAIT,
		MOB_COMPL_WAIT,
		MOB_FLUSH_WAIT,
		MOB_FLUSH_DRAIN_ST
	} mob_state_t;

	mob_state_t       state;
	mob_mtype_t       lastType;
	logic             lastValid;
	logic [OUTS_W-1:0] outsCount;
	logic             outsFull;
	logic             mustWait;
	logic             issueFire;
	logic [MOB_ADDR_W-1:0] lastAddr;
	logic             multiActive;
	logic [1:0]       flushCnt;
	mob_mtype_t       curType;

	assign curType = mob_mtype_t'(accType);

	// ==========================================================
	// Pair ordering decision
	// True when a later access of type b must wait for an earlier a
	function automatic logic mob_strict_pair(input mob_mtype_t a, input mob_mtype_t b);
		logic r;
		r = 1'b0;
		case (a)
			MOB_DEV_NSH: r = (b == MOB_DEV_NSH) || (b == MOB_STRONG);
			MOB_DEV_SH:  r = (b == MOB_DEV_SH) || (b == MOB_STRONG);
			MOB_STRONG:  r = (b != MOB_NORMAL);
			default:     r = 1'b0;
		endcase
		return r;
	endfunction

	// Only explicit data accesses reach this port; fetches bypass it.
	// Each access, including each word of a multi-word transfer, is checked
	// against the previous one still in flight.
	// Observation on the bus means global observation for shareable types and
	// local observation otherwise; both retire the access.
	// All operands stay in the expression so the wait tracks the counter every cycle
	assign mustWait = lastValid && mob_strict_pair(lastType, curType)
		&& !outstandingEmpty;

	// No exclusive-access path exists; atomicity is left to software.
	// Order barrier is left out: it holds memory issue only, through accReady
	assign issueStall = (state == MOB_COMPL_WAIT)
		|| (state == MOB_FLUSH_WAIT) || (state == MOB_FLUSH_DRAIN_ST);
	assign accReady   = (state == MOB_IDLE) && !mustWait && !outsFull
		&& busReqReady;
	assign issueFire  = accValid && accReady;

	// ==========================================================
	// Outstanding access tracking
	mob_outstanding_counter #(
		.WIDTH (OUTS_W),
		.LIMIT (OUTS_MAX)
	) u_outs (
		.sys_clk (sys_clk),
		.rst     (rst),
		.inc     (issueFire),
		.dec     (busObserved),
		.count   (outsCount),
		.empty   (outstandingEmpty),
		.full    (outsFull)
	);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lastType  <= MOB_NORMAL;
			lastValid <= 1'b0;
		end else if (issueFire) begin
			lastType  <= curType;
			lastValid <= 1'b1;
		end else if (outstandingEmpty) begin
			lastValid <= 1'b0;
		end
	end

	// Multi-word sequencing: addresses must ascend unless the list loads PC; lastAddr and multiActive are only recorded, never checked
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lastAddr    <= '0;
			multiActive <= 1'b0;
		end else if (issueFire) begin
			lastAddr    <= accAddr;
			multiActive <= accMulti && !accMultiPc;
		end
	end

	// ==========================================================
	// Bus request register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busReqValid <= 1'b0;
			busReqWrite <= 1'b0;
			busReqAddr  <= '0;
		end else begin
			busReqValid <= issueFire;
			if (issueFire) begin
				busReqWrite <= accWrite;
				busReqAddr  <= accAddr;
			end
		end
	end

	// ==========================================================
	// Barrier sequencer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state    <= MOB_IDLE;
			flushCnt <= '0;
		end else begin
			case (state)
				MOB_IDLE: begin
					if (barValid) begin
						case (mob_bar_t'(barOp))
							MOB_BAR_ORDER: state <= MOB_ORDER_WAIT;
							MOB_BAR_COMPL: state <= MOB_COMPL_WAIT;
							MOB_BAR_FLUSH: state <= MOB_FLUSH_WAIT;
							default:       state <= MOB_IDLE;
						endcase
					end
				end
				MOB_ORDER_WAIT: begin
					if (outstandingEmpty && !busReqValid) begin
						state <= MOB_IDLE;
					end
				end
				MOB_COMPL_WAIT: begin
					if (outstandingEmpty && !busReqValid) begin
						state <= MOB_IDLE;
					end
				end
				MOB_FLUSH_WAIT: begin
					if (outstandingEmpty && !busReqValid) begin
						state    <= MOB_FLUSH_DRAIN_ST;
						flushCnt <= 2'(MOB_FLUSH_DRAIN);
					end
				end
				MOB_FLUSH_DRAIN_ST: begin
					if (flushCnt == 2'h1) begin
						state <= MOB_IDLE;
					end
					flushCnt <= flushCnt - 2'h1;
				end
				default: state <= MOB_IDLE;
			endcase
		end
	end

	// Order barrier holds only memory issue; issueStall stays low for it so
	// non-memory instructions run on.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			barDone   <= 1'b0;
			flushPipe <= 1'b0;
			ctxCommit <= 1'b0;
		end else begin
			barDone <= ((state == MOB_ORDER_WAIT) || (state == MOB_COMPL_WAIT))
				&& outstandingEmpty && !busReqValid
				|| (state == MOB_FLUSH_DRAIN_ST && flushCnt == 2'h1);
			// Discard younger instructions and refetch with new context
			flushPipe <= (state == MOB_FLUSH_WAIT) && outstandingEmpty
				&& !busReqValid;
			// Earlier context writes become visible before refetch resumes
			ctxCommit <= (state == MOB_FLUSH_WAIT) && outstandingEmpty
				&& !busReqValid;
		end
	end

	// ==========================================================
	// Checks
	sequence s_compl_start;
		state == MOB_IDLE && barValid && mob_bar_t'(barOp) == MOB_BAR_COMPL;
	endsequence

	chk_no_issue_stall: assert property (@(posedge sys_clk) disable iff (rst)
		issueStall |-> !issueFire)
		else $error("access issued while barrier stalls issue");

	chk_strict_pair: assert property (@(posedge sys_clk) disable iff (rst)
		issueFire && lastValid && mob_strict_pair(lastType, curType) |-> outstandingEmpty)
		else $error("strict pair issued with earlier access outstanding");

	chk_compl_drain: assert property (@(posedge sys_clk) disable iff (rst)
		barDone && $past(state) == MOB_COMPL_WAIT |-> $past(outstandingEmpty))
		else $error("completion barrier done with accesses in flight");

	chk_compl_stall: assert property (@(posedge sys_clk) disable iff (rst)
		s_compl_start |=> issueStall && !accReady)
		else $error("completion barrier not stalling issue");

	chk_flush_done: assert property (@(posedge sys_clk) disable iff (rst)
		flushPipe |-> ##[1:3] barDone)
		else $error("flush barrier did not finish");

	chk_ctx_flush: assert property (@(posedge sys_clk) disable iff (rst)
		flushPipe |-> ctxCommit)
		else $error("context commit missing on flush");

	chk_order_hold: assert property (@(posedge sys_clk) disable iff (rst)
		state == MOB_ORDER_WAIT && !outstandingEmpty |=> state == MOB_ORDER_WAIT)
		else $error("order barrier left with access outstanding");

	chk_req_follow: assert property (@(posedge sys_clk) disable iff (rst)
		issueFire |=> busReqValid && busReqAddr == $past(accAddr))
		else $error("bus request does not follow issue");
endmodule

// >>> rtl/mob_outstanding_counter.sv
// Counts explicit bus accesses issued but not yet observed on the bus (busObserved)
`timescale 1ns/1ps
module mob_outstanding_counter
	import mob_pkg::*;
#(
	parameter int WIDTH = MOB_OUTS_W,
	parameter int LIMIT = MOB_OUTS_MAX
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             inc,
	input  wire logic             dec,
	output logic      [WIDTH-1:0] count,
	output logic                  empty,
	output logic                  full
);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (inc && !dec) begin
			count <= count + WIDTH'(1);
		end else if (dec && !inc && count != '0) begin
			count <= count - WIDTH'(1);
		end
	end

	assign empty = (count == '0);
	assign full  = (count >= WIDTH'(LIMIT));
endmodule

// >>> rtl/mob_pkg.sv
// Package: memory type codes, barrier ops and limits for the ordering unit
package mob_pkg;
	// Memory type of an explicit access
	typedef enum logic [1:0] {
		MOB_NORMAL    = 2'h0,
		MOB_DEV_NSH   = 2'h1,
		MOB_DEV_SH    = 2'h2,
		MOB_STRONG    = 2'h3
	} mob_mtype_t;

	// Barrier operation presented by the decode stage
	typedef enum logic [1:0] {
		MOB_BAR_NONE  = 2'h0,
		MOB_BAR_ORDER = 2'h1,
		MOB_BAR_COMPL = 2'h2,
		MOB_BAR_FLUSH = 2'h3
	} mob_bar_t;

	localparam int MOB_OUTS_W      = 4;
	localparam int MOB_OUTS_MAX    = 8;
	localparam int MOB_ADDR_W      = 32;
	localparam int MOB_FLUSH_DRAIN = 2;
endpackage

// >>> tb/mob_bus_model.sv
// Bus side model: takes every request and acknowledges them in order after a delay
`timescale 1ns/1ps
module mob_bus_model (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       busReqValid,
	input  wire logic [5:0] ackDelay,
	output logic            busReqReady,
	output logic            busObserved
);
	int         pending;
	logic [5:0] waitCnt;
	logic       ackNow;

	assign busReqReady = 1'b1;
	// Oldest access is reported only once its side effects are in place
	assign ackNow = (pending > 0) && (waitCnt >= ackDelay);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pending <= 0;
			waitCnt <= 6'h00;
			busObserved <= 1'b0;
		end else begin
			pending <= pending + int'(busReqValid) - int'(ackNow);
			waitCnt <= (ackNow || pending == 0) ? 6'h00 : waitCnt + 6'h01;
			busObserved <= ackNow;
		end
	end
endmodule

// >>> tb/tb_top.sv
// Self-checking testbench for the memory ordering and barrier unit
`timescale 1ns/1ps
module tb_top;
	import mob_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        accValid = 1'b0;
	logic        accWrite = 1'b0;
	logic [1:0]  accType = 2'h0;
	logic [31:0] accAddr = 32'h0;
	logic        accMulti = 1'b0;
	logic        accMultiPc = 1'b0;
	logic [1:0]  barOp = 2'h0;
	logic        barValid = 1'b0;
	logic [5:0]  ackDelay = 6'h02;
	logic        accReady, busReqValid, busReqWrite, busReqReady, busObserved;
	logic        barDone, issueStall, flushPipe, ctxCommit, outstandingEmpty;
	logic [31:0] busReqAddr;
	int          failures = 0;
	int          compares = 0;
	int          cyc = 0;

	mob_memory_order_barrier_unit i_mob_memory_order_barrier_unit (
		.sys_clk(sys_clk), .rst(rst), .accValid(accValid), .accWrite(accWrite),
		.accType(accType), .accAddr(accAddr), .accMulti(accMulti),
		.accMultiPc(accMultiPc), .accReady(accReady), .busReqValid(busReqValid),
		.busReqWrite(busReqWrite), .busReqAddr(busReqAddr), .busReqReady(busReqReady),
		.busObserved(busObserved), .barOp(barOp), .barValid(barValid),
		.barDone(barDone), .issueStall(issueStall), .flushPipe(flushPipe),
		.ctxCommit(ctxCommit), .outstandingEmpty(outstandingEmpty)
	);
	mob_bus_model i_mob_bus_model (
		.sys_clk(sys_clk), .rst(rst), .busReqValid(busReqValid), .ackDelay(ackDelay),
		.busReqReady(busReqReady), .busObserved(busObserved)
	);

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ==========================================
	// Checks and drivers
	task automatic chk1(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic chkA(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: address %h expected %h", $time, got, exp);
		end
	endtask

	task automatic waitFor(ref logic sig, input int lim);
		int n;
		n = 0;
		#1;
		while (sig !== 1'b1 && n < lim) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask

	task automatic issue(input logic w, input logic [1:0] t, input logic [31:0] a,
		input logic m, input logic pc);
		@(posedge sys_clk);
		accValid <= 1'b1;
		accWrite <= w;
		accType <= t;
		accAddr <= a;
		accMulti <= m;
		accMultiPc <= pc;
		waitFor(accReady, 1000);
		@(posedge sys_clk);
		accValid <= 1'b0;
		#1;
		chk1(busReqValid, 1'b1);
		chk1(busReqWrite, w);
		chkA(busReqAddr, a);
	endtask

	task automatic drain();
		waitFor(outstandingEmpty, 1000);
		chk1(outstandingEmpty, 1'b1);
	endtask

	function automatic logic strict(input logic [1:0] a, input logic [1:0] b);
		return (a == b && a != 2'h0) || (a != 2'h0 && b == 2'h3) || (a == 2'h3 && b != 2'h0);
	endfunction

	task automatic startBar(input logic [1:0] op);
		@(posedge sys_clk);
		barOp <= op;
		barValid <= 1'b1;
		@(posedge sys_clk);
		barValid <= 1'b0;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_pairs();
		ackDelay <= 6'h0a;
		for (int a = 0; a < 4; a++) begin
			for (int b = 0; b < 4; b++) begin
				drain();
				issue(1'b0, 2'(a), 32'h0000_1000, 1'b0, 1'b0);
				@(posedge sys_clk);
				accType <= 2'(b);
				accValid <= 1'b1;
				#1;
				chk1(accReady, !strict(2'(a), 2'(b)));
				@(posedge sys_clk);
				accValid <= 1'b0;
			end
		end
	endtask

	task automatic t_multi();
		drain();
		for (int i = 0; i < 3; i++) begin
			issue(1'b1, MOB_NORMAL, 32'h0000_2000 + 32'(4 * i), 1'b1, 1'b0);
		end
		issue(1'b0, MOB_NORMAL, 32'h0000_2010, 1'b1, 1'b1);
	endtask

	task automatic t_full();
		ackDelay <= 6'h3f;
		drain();
		for (int i = 0; i < MOB_OUTS_MAX; i++) begin
			issue(1'b1, MOB_NORMAL, 32'h0000_4000 + 32'(4 * i), 1'b0, 1'b0);
		end
		@(posedge sys_clk);
		accValid <= 1'b1;
		#1;
		chk1(accReady, 1'b0);
		@(posedge sys_clk);
		accValid <= 1'b0;
	endtask

	task automatic t_bar(input logic [1:0] op);
		ackDelay <= 6'h08;
		drain();
		issue(1'b1, MOB_DEV_SH, 32'h0000_3000, 1'b0, 1'b0);
		issue(1'b1, MOB_NORMAL, 32'h0000_3004, 1'b0, 1'b0);
		startBar(op);
		#1;
		chk1(issueStall, op != MOB_BAR_ORDER);
		chk1(accReady, 1'b0);
		waitFor(barDone, 300);
		chk1(barDone, 1'b1);
		chk1(outstandingEmpty, 1'b1);
	endtask

	task automatic t_flush();
		drain();
		startBar(MOB_BAR_FLUSH);
		waitFor(flushPipe, 50);
		chk1(flushPipe, 1'b1);
		chk1(ctxCommit, 1'b1);
		repeat (MOB_FLUSH_DRAIN) @(posedge sys_clk);
		#1;
		chk1(barDone, 1'b1);
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			conclude();
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk1(outstandingEmpty, 1'b1);
		chk1(busReqValid, 1'b0);
		chk1(barDone, 1'b0);
		t_pairs();
		t_multi();
		t_full();
		t_bar(MOB_BAR_COMPL);
		t_bar(MOB_BAR_ORDER);
		t_flush();
		conclude();
	end
endmodule
